/* File: hw/flash_program_erase_commands.sv */
`timescale 1ns/1ps
module flash_program_erase_commands #(
    parameter int FLASH_BYTES = 128
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_cmd_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int FLASH_WORDS = FLASH_BYTES / 2;
    localparam int AW_F = $clog2(FLASH_WORDS);
    localparam int AW_O = $clog2(nvm_cmd_pkg::ONCE_WORDS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ONCE_CHECK,
        ST_PROGRAM,
        ST_VERIFY,
        ST_ERASE,
        ST_ERASE_VERIFY
    } seq_state_t;

    ////////////////////////////////////////////////////////////////////////
    // state

    seq_state_t state;
    logic [15:0] step;
    logic op_once;
    logic [2:0] op_words;
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic verify_fault_any;
    logic verify_fault_uncorrectable;
    logic [2:0] command_object_index;
    logic [15:0] command_object [nvm_cmd_pkg::SLOT_COUNT];
    logic [2:0] mode_enable;
    logic prot_enable;
    logic [15:0] prot_base;
    logic secured;
    logic [15:0] read_addr;

    nvm_array_if #(.AW(AW_F)) flash_bus ();
    nvm_array_if #(.AW(AW_O)) once_bus ();

    nvm_word_array #(.DEPTH(FLASH_WORDS)) u_flash (
        .pclk(pclk),
        .presetn(presetn),
        .bus(flash_bus.store)
    );

    nvm_word_array #(.DEPTH(nvm_cmd_pkg::ONCE_WORDS)) u_once (
        .pclk(pclk),
        .presetn(presetn),
        .bus(once_bus.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic access;
    logic wr_en;
    logic busy;
    logic [7:0] command_object_high_byte;
    logic [7:0] command_object_low_byte;
    logic [15:0] gaddr;

    assign access = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite;
    assign busy = ~command_complete_flag;
    assign command_object_high_byte = command_object[0][15:8];
    assign command_object_low_byte = command_object[0][7:0];
    assign gaddr = command_object[1];

    logic wr_status;
    logic wr_cfg_ok;

    assign wr_status = wr_en && paddr == nvm_cmd_pkg::OFF_STATUS;
    // writes other than to status are dropped while a command runs
    assign wr_cfg_ok = wr_en && !busy;

    logic [31:0] rd_value;
    logic addr_hit;

    always_comb begin
        rd_value = 32'h0000_0000;
        addr_hit = 1'b1;
        if (paddr == nvm_cmd_pkg::OFF_STATUS) begin
            rd_value[nvm_cmd_pkg::BIT_COMPLETE] = command_complete_flag;
            rd_value[nvm_cmd_pkg::BIT_ACCESS_ERR] = access_error_flag;
            rd_value[nvm_cmd_pkg::BIT_PROT_VIOL] = protection_violation_flag;
            rd_value[nvm_cmd_pkg::BIT_VERIFY_ANY] = verify_fault_any;
            rd_value[nvm_cmd_pkg::BIT_VERIFY_UNCORR] = verify_fault_uncorrectable;
        end else if (paddr == nvm_cmd_pkg::OFF_INDEX) begin
            rd_value[2:0] = command_object_index;
        end else if (paddr == nvm_cmd_pkg::OFF_OBJECT) begin
            if (command_object_index < 3'(nvm_cmd_pkg::SLOT_COUNT)) begin
                rd_value[15:0] = command_object[command_object_index];
            end
        end else if (paddr == nvm_cmd_pkg::OFF_CONFIG) begin
            rd_value[2:0] = mode_enable;
            rd_value[nvm_cmd_pkg::BIT_PROT_ENABLE] = prot_enable;
            rd_value[nvm_cmd_pkg::POS_PROT_BASE +: 16] = prot_base;
        end else if (paddr == nvm_cmd_pkg::OFF_SECURITY) begin
            rd_value[0] = secured;
        end else if (paddr == nvm_cmd_pkg::OFF_READ_ADDR) begin
            rd_value[15:0] = read_addr;
        end else if (paddr == nvm_cmd_pkg::OFF_READ_DATA) begin
            // the array port belongs to the sequencer while it runs
            rd_value[15:0] = busy ? nvm_cmd_pkg::INVALID_READ : flash_bus.rdata;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // one wait state: the answer is registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_value;
            pslverr <= ~addr_hit;
        end else begin
            // error only stands beside its pready pulse
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // launch checks

    logic launch;
    logic [2:0] pf_words;
    logic [16:0] pf_last;
    logic launch_acc;
    logic launch_prot;

    assign launch = wr_status && pwdata[nvm_cmd_pkg::BIT_COMPLETE] && command_complete_flag;
    assign pf_words = (command_object_index == nvm_cmd_pkg::IDX_TWO_LONGWORDS) ? 3'd4 : 3'd2;
    assign pf_last = 17'({1'b0, gaddr} + {13'h0000, pf_words, 1'b0} - 17'h0_0001);

    always_comb begin
        launch_acc = 1'b0;
        launch_prot = 1'b0;
        if (command_object_high_byte == nvm_cmd_pkg::CMD_PROGRAM_FLASH) begin
            launch_acc = (command_object_index != nvm_cmd_pkg::IDX_ONE_LONGWORD
                && command_object_index != nvm_cmd_pkg::IDX_TWO_LONGWORDS)
                || gaddr[1:0] != 2'b00
                || pf_last >= 17'(FLASH_BYTES)
                || !mode_enable[nvm_cmd_pkg::BIT_MODE_PROGRAM]
                || command_object_low_byte != nvm_cmd_pkg::FLASH_BLOCK_SEL
                || {1'b0, gaddr} >= 17'(FLASH_BYTES);
            launch_prot = prot_enable && pf_last >= {1'b0, prot_base};
        end else if (command_object_high_byte == nvm_cmd_pkg::CMD_PROGRAM_ONCE) begin
            launch_acc = command_object_index != nvm_cmd_pkg::IDX_ONCE
                || gaddr > nvm_cmd_pkg::ONCE_LAST_PHRASE
                || !mode_enable[nvm_cmd_pkg::BIT_MODE_ONCE];
        end else if (command_object_high_byte == nvm_cmd_pkg::CMD_ERASE_ALL) begin
            launch_acc = command_object_index != nvm_cmd_pkg::IDX_ERASE_ALL
                || !mode_enable[nvm_cmd_pkg::BIT_MODE_ERASE_ALL];
            launch_prot = prot_enable;
        end else begin
            launch_acc = 1'b1;
        end
    end

    logic launch_ok;

    // a refused launch never leaves idle, so nothing reaches the arrays
    assign launch_ok = launch && !launch_acc && !launch_prot;

    ////////////////////////////////////////////////////////////////////////
    // sequencer datapath

    logic [15:0] expect_word;
    logic [15:0] seen_word;
    logic [15:0] diff;
    logic mismatch;
    logic uncorrectable;
    logic last_data_step;
    logic last_flash_step;

    assign expect_word = command_object[step[1:0] + nvm_cmd_pkg::SLOT_FIRST_DATA];
    assign seen_word = op_once ? once_bus.rdata : flash_bus.rdata;
    assign diff = (state == ST_ERASE_VERIFY) ? (seen_word ^ nvm_cmd_pkg::ERASED_WORD) : (seen_word ^ expect_word);
    assign mismatch = diff != 16'h0000;
    // a single flipped bit is treated as correctable, two or more are not
    assign uncorrectable = (diff & (diff - 16'h0001)) != 16'h0000;
    assign last_data_step = step == 16'(op_words - 3'd1);
    assign last_flash_step = step == 16'(FLASH_WORDS - 1);

    always_comb begin
        flash_bus.addr = busy ? AW_F'(gaddr[15:1] + step[14:0]) : AW_F'(read_addr[15:1]);
        if (state == ST_ERASE_VERIFY) begin
            flash_bus.addr = AW_F'(step);
        end
        flash_bus.wdata = expect_word;
        flash_bus.prog = state == ST_PROGRAM && !op_once;
        flash_bus.erase = state == ST_ERASE;
        once_bus.addr = AW_O'({gaddr[2:0], step[1:0]});
        once_bus.wdata = expect_word;
        once_bus.prog = state == ST_PROGRAM && op_once;
        once_bus.erase = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            step <= 16'h0000;
            op_once <= 1'b0;
            op_words <= 3'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    step <= 16'h0000;
                    if (launch_ok) begin
                        op_once <= command_object_high_byte == nvm_cmd_pkg::CMD_PROGRAM_ONCE;
                        op_words <= (command_object_high_byte == nvm_cmd_pkg::CMD_PROGRAM_ONCE) ? 3'd4 : pf_words;
                        if (command_object_high_byte == nvm_cmd_pkg::CMD_PROGRAM_ONCE) begin
                            state <= ST_ONCE_CHECK;
                        end else if (command_object_high_byte == nvm_cmd_pkg::CMD_ERASE_ALL) begin
                            state <= ST_ERASE;
                        end else begin
                            state <= ST_PROGRAM;
                        end
                    end
                end
                ST_ONCE_CHECK: begin
                    // an all-ones phrase reads as erased and may be written again
                    if (once_bus.rdata != nvm_cmd_pkg::ERASED_WORD) begin
                        state <= ST_IDLE;
                    end else if (last_data_step) begin
                        state <= ST_PROGRAM;
                        step <= 16'h0000;
                    end else begin
                        step <= step + 16'h0001;
                    end
                end
                ST_PROGRAM: begin
                    if (last_data_step) begin
                        state <= ST_VERIFY;
                        step <= 16'h0000;
                    end else begin
                        step <= step + 16'h0001;
                    end
                end
                ST_VERIFY: begin
                    if (last_data_step) begin
                        state <= ST_IDLE;
                    end else begin
                        step <= step + 16'h0001;
                    end
                end
                ST_ERASE: begin
                    state <= ST_ERASE_VERIFY;
                    step <= 16'h0000;
                end
                ST_ERASE_VERIFY: begin
                    if (last_flash_step) begin
                        state <= ST_IDLE;
                    end else begin
                        step <= step + 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    logic seq_done;
    logic once_refused;

    assign once_refused = state == ST_ONCE_CHECK && once_bus.rdata != nvm_cmd_pkg::ERASED_WORD;
    assign seq_done = (state == ST_VERIFY && last_data_step)
        || (state == ST_ERASE_VERIFY && last_flash_step) || once_refused;

    ////////////////////////////////////////////////////////////////////////
    // status flags

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag <= 1'b1;
        end else if (launch_ok) begin
            command_complete_flag <= 1'b0;
        end else if (seq_done) begin
            command_complete_flag <= 1'b1;
        end
    end

    // hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_error_flag <= 1'b0;
        end else if ((launch && launch_acc) || once_refused) begin
            access_error_flag <= 1'b1;
        end else if (wr_status && pwdata[nvm_cmd_pkg::BIT_ACCESS_ERR]) begin
            access_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_violation_flag <= 1'b0;
        end else if (launch && launch_prot) begin
            protection_violation_flag <= 1'b1;
        end else if (wr_status && pwdata[nvm_cmd_pkg::BIT_PROT_VIOL]) begin
            protection_violation_flag <= 1'b0;
        end
    end

    // verify results belong to the last command, so an accepted launch clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verify_fault_any <= 1'b0;
            verify_fault_uncorrectable <= 1'b0;
        end else if (launch_ok) begin
            verify_fault_any <= 1'b0;
            verify_fault_uncorrectable <= 1'b0;
        end else if (state == ST_VERIFY || state == ST_ERASE_VERIFY) begin
            verify_fault_any <= verify_fault_any | mismatch;
            verify_fault_uncorrectable <= verify_fault_uncorrectable | uncorrectable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secured <= nvm_cmd_pkg::RESET_SECURED;
        end else if (state == ST_ERASE_VERIFY && last_flash_step && !verify_fault_any && !mismatch) begin
            secured <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_object_index <= 3'h0;
        end else if (wr_cfg_ok && paddr == nvm_cmd_pkg::OFF_INDEX) begin
            command_object_index <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < nvm_cmd_pkg::SLOT_COUNT; i++) begin
                command_object[i] <= 16'h0000;
            end
        end else if (wr_cfg_ok && paddr == nvm_cmd_pkg::OFF_OBJECT
                     && command_object_index < 3'(nvm_cmd_pkg::SLOT_COUNT)) begin
            command_object[command_object_index] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_enable <= nvm_cmd_pkg::RESET_MODE_ENABLE;
            prot_enable <= 1'b0;
            prot_base <= nvm_cmd_pkg::RESET_PROT_BASE;
        end else if (wr_cfg_ok && paddr == nvm_cmd_pkg::OFF_CONFIG) begin
            mode_enable <= pwdata[2:0];
            prot_enable <= pwdata[nvm_cmd_pkg::BIT_PROT_ENABLE];
            prot_base <= pwdata[nvm_cmd_pkg::POS_PROT_BASE +: 16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_addr <= 16'h0000;
        end else if (wr_cfg_ok && paddr == nvm_cmd_pkg::OFF_READ_ADDR) begin
            read_addr <= pwdata[15:0];
        end
    end
endmodule : flash_program_erase_commands

/* File: hw/nvm_cmd_pkg.sv */
package nvm_cmd_pkg;
    // register byte offsets on the apb port
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_INDEX = 8'h04;
    localparam logic [7:0] OFF_OBJECT = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_SECURITY = 8'h10;
    localparam logic [7:0] OFF_READ_ADDR = 8'h14;
    localparam logic [7:0] OFF_READ_DATA = 8'h18;

    // status register bit positions
    localparam int BIT_COMPLETE = 7;
    localparam int BIT_ACCESS_ERR = 5;
    localparam int BIT_PROT_VIOL = 4;
    localparam int BIT_VERIFY_ANY = 1;
    localparam int BIT_VERIFY_UNCORR = 0;

    // config register fields
    localparam int BIT_MODE_PROGRAM = 0;
    localparam int BIT_MODE_ONCE = 1;
    localparam int BIT_MODE_ERASE_ALL = 2;
    localparam int BIT_PROT_ENABLE = 8;
    localparam int POS_PROT_BASE = 16;
    localparam logic [2:0] RESET_MODE_ENABLE = 3'h7;
    localparam logic [15:0] RESET_PROT_BASE = 16'hffff;
    localparam logic RESET_SECURED = 1'b1;

    // command codes and the slot index each needs at launch
    localparam logic [7:0] CMD_PROGRAM_FLASH = 8'h06;
    localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
    localparam logic [2:0] IDX_ONE_LONGWORD = 3'h3;
    localparam logic [2:0] IDX_TWO_LONGWORDS = 3'h5;
    localparam logic [2:0] IDX_ONCE = 3'h5;
    localparam logic [2:0] IDX_ERASE_ALL = 3'h0;
    localparam int SLOT_COUNT = 6;
    localparam logic [2:0] SLOT_FIRST_DATA = 3'h2;

    // memory layout
    localparam logic [7:0] FLASH_BLOCK_SEL = 8'h00;
    localparam logic [15:0] ONCE_LAST_PHRASE = 16'h0007;
    localparam int ONCE_WORDS = 32;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [15:0] INVALID_READ = 16'h0000;
endpackage : nvm_cmd_pkg

/* File: hw/nvm_array_if.sv */
`timescale 1ns/1ps
interface nvm_array_if #(parameter int AW = 6);
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic prog;
    logic erase;
    logic [15:0] rdata;
    modport ctrl(output addr, output wdata, output prog, output erase, input rdata);
    modport store(input addr, input wdata, input prog, input erase, output rdata);
endinterface : nvm_array_if

/* File: hw/nvm_word_array.sv */
`timescale 1ns/1ps
module nvm_word_array #(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // array port
    nvm_array_if.store bus
);
    logic [15:0] mem [DEPTH];

    assign bus.rdata = mem[bus.addr];

    // programming can only clear bits, so a second program of a word
    // merges with the old contents and the read-back exposes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= nvm_cmd_pkg::ERASED_WORD;
            end
        end else if (bus.erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= nvm_cmd_pkg::ERASED_WORD;
            end
        end else if (bus.prog) begin
            mem[bus.addr] <= mem[bus.addr] & bus.wdata;
        end
    end
endmodule : nvm_word_array

/* File: tb/flash_program_erase_commands_monitor.sv */
`timescale 1ns/1ps
module flash_program_erase_commands_monitor #(
    parameter int FLASH_BYTES = 128
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_cmd_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_one_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("answer while not selected");
    a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data on a write");
    a_unmapped_err: assert property (pready && paddr > nvm_cmd_pkg::OFF_READ_DATA |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && paddr <= nvm_cmd_pkg::OFF_READ_DATA && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_word_width: assert property (pready && !pwrite && (paddr == nvm_cmd_pkg::OFF_OBJECT ||
        paddr == nvm_cmd_pkg::OFF_READ_DATA) |-> prdata[31:16] == 16'h0000)
        else $error("upper half of word not zero");
endmodule : flash_program_erase_commands_monitor

/* File: tb/flash_program_erase_commands_tb_top.sv */
`timescale 1ns/1ps
module flash_program_erase_commands_tb_top;
    // expected answer of one transfer; mask zero means data is not compared
    typedef struct {
        logic [31:0] data;
        logic [31:0] mask;
        logic err;
    } note_t;
    localparam int FB = 128;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] seed = 32'h0000_c7e8;
    logic [31:0] r;
    logic [15:0] slot [6];
    logic [15:0] w [4];
    logic [15:0] pf0;
    logic [15:0] po0;
    logic [15:0] ea0;
    int mismatches = 0;
    int n_tests = 0;
    note_t q [$];

    always #25 pclk = ~pclk;

    flash_program_erase_commands #(.FLASH_BYTES(FB)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // the watcher pairs every answer with the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1 && q.size() > 0) begin
            check("prdata", prdata & q[0].mask, q[0].data & q[0].mask);
            check("pslverr", {31'h0, pslverr}, {31'h0, q[0].err});
            void'(q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one idle cycle after each transfer keeps psel from being assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                       input logic [31:0] m, input logic e);
        q.push_back('{exp, m, e});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, exp, 32'hffff_ffff, 1'b0);
    endtask : rd

    task automatic fr(input logic [15:0] a, input logic [15:0] exp);
        wr(nvm_cmd_pkg::OFF_READ_ADDR, {16'h0000, a});
        rd(nvm_cmd_pkg::OFF_READ_DATA, {16'h0000, exp});
    endtask : fr

    // loads slots 0 and 1 from s0 and a and slots 2 to 5 from w, launches, optionally reads flash while busy, then polls
    task automatic cmd(input logic [15:0] s0, input logic [15:0] a, input logic [2:0] ix, input logic [7:0] exp,
                       input logic b);
        slot[0] = s0;
        slot[1] = a;
        for (int i = 0; i < 4; i++) slot[i + 2] = w[i];
        wr(nvm_cmd_pkg::OFF_STATUS, 32'h0000_0030);
        for (int i = 0; i < 6; i++) begin
            wr(nvm_cmd_pkg::OFF_INDEX, 32'(i));
            wr(nvm_cmd_pkg::OFF_OBJECT, {16'h0000, slot[i]});
        end
        wr(nvm_cmd_pkg::OFF_INDEX, {29'h0, ix});
        wr(nvm_cmd_pkg::OFF_STATUS, 32'h0000_0080);
        if (b) rd(nvm_cmd_pkg::OFF_READ_DATA, 32'h0000_0000);
        do apb(1'b0, nvm_cmd_pkg::OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0); while (r[7] !== 1'b1);
        apb(1'b0, nvm_cmd_pkg::OFF_STATUS, 32'h0, {24'h0, exp}, 32'h0000_00b3, 1'b0);
    endtask : cmd

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pf0 = {nvm_cmd_pkg::CMD_PROGRAM_FLASH, nvm_cmd_pkg::FLASH_BLOCK_SEL};
        po0 = {nvm_cmd_pkg::CMD_PROGRAM_ONCE, 8'h00};
        ea0 = {nvm_cmd_pkg::CMD_ERASE_ALL, 8'h00};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(nvm_cmd_pkg::OFF_STATUS, 32'h0000_0080);
        rd(nvm_cmd_pkg::OFF_CONFIG, 32'hffff_0007);
        rd(nvm_cmd_pkg::OFF_SECURITY, 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) w[i] = xs();
        cmd(pf0, 16'h0010, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h80, 1'b0);
        fr(16'h0010, w[0]);
        fr(16'h0012, w[1]);
        fr(16'h0014, 16'hffff);
        cmd(pf0, 16'h0078, nvm_cmd_pkg::IDX_TWO_LONGWORDS, 8'h80, 1'b0);
        fr(16'h007e, w[3]);
        for (int i = 0; i < 8; i++) begin
            if (i != 3 && i != 5) cmd(pf0, 16'h0030, 3'(i), 8'ha0, 1'b0);
        end
        cmd(pf0, 16'h0032, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'ha0, 1'b0);
        cmd(pf0 | 16'h0001, 16'h0030, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'ha0, 1'b0);
        w[2] = ~w[2];
        cmd(pf0, 16'h007c, nvm_cmd_pkg::IDX_TWO_LONGWORDS, 8'ha0, 1'b0);
        fr(16'h007c, ~w[2]);
        $display("test program done");
        w = '{16'hfffe, 16'hffff, 16'hffff, 16'hffff};
        cmd(pf0, 16'h0020, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h80, 1'b0);
        w[0] = 16'hffff;
        cmd(pf0, 16'h0020, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h82, 1'b0);
        w[0] = 16'hfffc;
        cmd(pf0, 16'h0028, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h80, 1'b0);
        w[0] = 16'hffff;
        cmd(pf0, 16'h0028, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h83, 1'b0);
        $display("test verify done");
        // each mode bit cleared in turn refuses only its own command
        // verify bits of the last good command survive refused launches
        wr(nvm_cmd_pkg::OFF_CONFIG, 32'hffff_0006);
        cmd(pf0, 16'h0030, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'ha3, 1'b0);
        wr(nvm_cmd_pkg::OFF_CONFIG, 32'hffff_0005);
        cmd(po0, 16'h0002, nvm_cmd_pkg::IDX_ONCE, 8'ha3, 1'b0);
        wr(nvm_cmd_pkg::OFF_CONFIG, 32'hffff_0003);
        cmd(ea0, 16'h0000, nvm_cmd_pkg::IDX_ERASE_ALL, 8'ha3, 1'b0);
        wr(nvm_cmd_pkg::OFF_CONFIG, 32'h0040_0107);
        rd(nvm_cmd_pkg::OFF_CONFIG, 32'h0040_0107);
        cmd(pf0, 16'h0040, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h93, 1'b0);
        cmd(pf0, 16'h003c, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'h80, 1'b0);
        cmd(ea0, 16'h0000, nvm_cmd_pkg::IDX_ERASE_ALL, 8'h90, 1'b0);
        wr(nvm_cmd_pkg::OFF_CONFIG, 32'hffff_0007);
        $display("test mode done");
        for (int i = 0; i < 4; i++) w[i] = xs() & 16'h7fff;
        wr(nvm_cmd_pkg::OFF_READ_ADDR, 32'h0000_0014);
        cmd(po0, 16'h0000, nvm_cmd_pkg::IDX_ONCE, 8'h80, 1'b1);
        cmd(po0, 16'h0000, nvm_cmd_pkg::IDX_ONCE, 8'ha0, 1'b0);
        cmd(po0, 16'h0008, nvm_cmd_pkg::IDX_ONCE, 8'ha0, 1'b0);
        cmd(po0, 16'h0003, nvm_cmd_pkg::IDX_ONE_LONGWORD, 8'ha0, 1'b0);
        w = '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
        cmd(po0, 16'h0001, nvm_cmd_pkg::IDX_ONCE, 8'h80, 1'b0);
        cmd(po0, 16'h0001, nvm_cmd_pkg::IDX_ONCE, 8'h80, 1'b0);
        $display("test once done");
        cmd(ea0, 16'h0000, 3'h1, 8'ha0, 1'b0);
        rd(nvm_cmd_pkg::OFF_SECURITY, 32'h0000_0001);
        wr(nvm_cmd_pkg::OFF_READ_ADDR, 32'h0000_0010);
        cmd(ea0, 16'h0000, nvm_cmd_pkg::IDX_ERASE_ALL, 8'h80, 1'b1);
        rd(nvm_cmd_pkg::OFF_SECURITY, 32'h0000_0000);
        fr(16'h0010, 16'hffff);
        $display("test erase done");
        report_and_stop();
    end
endmodule : flash_program_erase_commands_tb_top

bind flash_program_erase_commands flash_program_erase_commands_monitor #(.FLASH_BYTES(FLASH_BYTES)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
